//--- hw/csfc_charge_ctrl.sv
// charge state machine, short protection and axi4-lite registers
// assumes: analog comparator flags on pins, open-drain pads outside
//
// Implementation choices: the placing of the registers and register access over AXI4-Lite.
`include "csfc_consts.svh"

module csfc_charge_ctrl (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // analog flags and enable pin
  input wire csfc_pkg::csfc_flags_type flags_in,
  input wire logic chip_enable,
  // power switch and indicator drives
  output csfc_pkg::csfc_drive_type drive,
  // axi4-lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  localparam int FW = $bits(csfc_pkg::csfc_flags_type);

  typedef struct packed {
    csfc_pkg::csfc_state_type state;
    logic fault_below;
    logic en_prev;
    logic [15:0] tick_cnt;
    logic [31:0] pre_time;
    logic [31:0] chg_time;
    logic [31:0] ctrl;
    logic [31:0] pre_limit;
    logic [31:0] chg_limit;
    logic [7:0] waddr;
    logic wa_have;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wd_have;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic aw_rdy;
    logic w_rdy;
    logic ar_rdy;
    logic in_short;
    logic cell_short;
    csfc_pkg::csfc_drive_type drv;
  } csfc_ctrl_state_type;

  csfc_ctrl_state_type st_reg;
  csfc_ctrl_state_type st_next;
  csfc_pkg::csfc_flags_type fl;
  logic [FW:0] raw_sync;
  logic en_sync;

  // ==========================================================
  // pin synchronisation
  csfc_sync3 #(.WIDTH(FW + 1)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .din({chip_enable, flags_in}),
    .dout(raw_sync)
  );
  assign fl = raw_sync[FW-1:0];
  assign en_sync = raw_sync[FW];

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return res;
  endfunction : merge

  always_comb begin
    logic enabled;
    logic tick;
    logic charging;
    logic toggled;
    logic timers_off;
    enabled = 1'b0;
    tick = 1'b0;
    charging = 1'b0;
    toggled = 1'b0;
    timers_off = 1'b0;
    st_next = st_reg;

    // ==========================================================
    // timer tick divider
    if (st_reg.tick_cnt == 16'(`CSFC_TICK_CYCLES - 1)) begin
      st_next.tick_cnt = '0;
      tick = 1'b1;
    end else begin
      st_next.tick_cnt = st_reg.tick_cnt + 16'h0001;
    end

    enabled = en_sync && st_reg.ctrl[`CSFC_CTRL_EN_BIT];
    st_next.en_prev = enabled;
    toggled = enabled && !st_reg.en_prev;
    timers_off = fl.timer_at_ref;

    // ==========================================================
    // charge state machine
    unique case (st_reg.state)
      csfc_pkg::ST_SLEEP, csfc_pkg::ST_STANDBY: begin
        st_next.pre_time = '0;
        st_next.chg_time = '0;
        // a floating path pin parks the charger here instead of bouncing
        if (st_reg.state == csfc_pkg::ST_STANDBY && enabled && fl.input_present &&
            !fl.path_floating) begin
          if (!fl.temp_ok) begin
            st_next.state = csfc_pkg::ST_SUSPEND;
          end else begin
            st_next.state = fl.below_precharge ? csfc_pkg::ST_PRE : csfc_pkg::ST_FAST;
          end
        end
      end
      csfc_pkg::ST_PRE, csfc_pkg::ST_FAST: begin
        charging = 1'b1;
        if (!fl.temp_ok) begin
          st_next.state = csfc_pkg::ST_SUSPEND;
        end else if (!timers_off && ((st_reg.state == csfc_pkg::ST_PRE &&
                     st_reg.pre_time >= st_reg.pre_limit) ||
                     st_reg.chg_time >= st_reg.chg_limit)) begin
          st_next.state = csfc_pkg::ST_FAULT;
          st_next.fault_below = fl.below_recharge;
        end else if (st_reg.state == csfc_pkg::ST_FAST && fl.in_regulation &&
                     fl.term_detect && !timers_off) begin
          st_next.state = csfc_pkg::ST_DONE;
        end else begin
          st_next.state = fl.below_precharge ? csfc_pkg::ST_PRE : csfc_pkg::ST_FAST;
        end
        if (tick && st_reg.state == csfc_pkg::ST_PRE) begin
          st_next.pre_time = st_reg.pre_time + 32'h1;
        end
        if (tick) begin
          st_next.chg_time = st_reg.chg_time + 32'h1;
        end
      end
      csfc_pkg::ST_DONE: begin
        if (fl.below_recharge) begin
          st_next.state = csfc_pkg::ST_PRE;
          st_next.pre_time = '0;
          st_next.chg_time = '0;
        end
      end
      csfc_pkg::ST_SUSPEND: begin
        // timers held, not cleared
        if (fl.temp_ok) begin
          st_next.state = fl.below_precharge ? csfc_pkg::ST_PRE : csfc_pkg::ST_FAST;
        end
      end
      csfc_pkg::ST_FAULT: begin
        if (!fl.below_recharge) begin
          st_next.fault_below = 1'b0;
        end else if (!st_reg.fault_below || timers_off) begin
          st_next.state = csfc_pkg::ST_PRE;
          st_next.pre_time = '0;
          st_next.chg_time = '0;
        end
      end
      default: st_next.state = csfc_pkg::ST_SLEEP;
    endcase
    // enable toggle also clears a latched fault
    if (st_reg.state == csfc_pkg::ST_FAULT && toggled) begin
      st_next.state = csfc_pkg::ST_STANDBY;
    end
    // floating path pin stops charging
    if (fl.path_floating && (charging || st_reg.state == csfc_pkg::ST_SUSPEND)) begin
      st_next.state = csfc_pkg::ST_STANDBY;
    end
    if (!enabled && st_reg.state != csfc_pkg::ST_FAULT) begin
      st_next.state = csfc_pkg::ST_STANDBY;
    end
    if (!fl.input_present) begin
      st_next.state = csfc_pkg::ST_SLEEP;
    end else if (st_reg.state == csfc_pkg::ST_SLEEP) begin
      st_next.state = csfc_pkg::ST_STANDBY;
    end

    // ==========================================================
    // short-circuit protection
    st_next.in_short = fl.input_present && fl.out_below_1v;
    st_next.cell_short = fl.out_below_cell && !fl.path_below_1v;

    // ==========================================================
    // drives
    st_next.drv.input_switch_on = fl.input_present && enabled && !st_reg.in_short;
    st_next.drv.input_pullup_on = st_reg.in_short;
    st_next.drv.cell_switch_on = !st_reg.cell_short;
    st_next.drv.cell_source_on = st_reg.cell_short;
    st_next.drv.charge_switch_on = (st_reg.state == csfc_pkg::ST_PRE ||
                                   st_reg.state == csfc_pkg::ST_FAST) && !fl.path_floating;
    st_next.drv.precharge_sel = st_reg.state == csfc_pkg::ST_PRE;
    st_next.drv.fault_probe_current = st_reg.state == csfc_pkg::ST_FAULT &&
                                      st_reg.fault_below && fl.below_recharge;
    st_next.drv.status_a_oe = en_sync && (st_reg.state == csfc_pkg::ST_PRE ||
                              st_reg.state == csfc_pkg::ST_FAST);
    st_next.drv.status_b_oe = en_sync && (st_reg.state == csfc_pkg::ST_PRE ||
                              st_reg.state == csfc_pkg::ST_DONE);
    st_next.drv.power_good_oe = st_reg.state != csfc_pkg::ST_SLEEP;

    // ==========================================================
    // axi4-lite write channel
    if (s_axi_awvalid && !st_reg.wa_have) begin
      st_next.wa_have = 1'b1;
      st_next.waddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st_reg.wd_have) begin
      st_next.wd_have = 1'b1;
      st_next.wdata = s_axi_wdata;
      st_next.wstrb = s_axi_wstrb;
    end
    if (st_reg.wa_have && st_reg.wd_have && !st_reg.bvalid) begin
      st_next.wa_have = 1'b0;
      st_next.wd_have = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp = `CSFC_AXI_OKAY;
      unique case (st_reg.waddr)
        `CSFC_CTRL_OFF: st_next.ctrl = merge(st_reg.ctrl, st_reg.wdata, st_reg.wstrb);
        `CSFC_PRE_LIMIT_OFF: st_next.pre_limit = merge(st_reg.pre_limit, st_reg.wdata,
                                                       st_reg.wstrb);
        `CSFC_CHG_LIMIT_OFF: st_next.chg_limit = merge(st_reg.chg_limit, st_reg.wdata,
                                                       st_reg.wstrb);
        `CSFC_STATUS_OFF, `CSFC_FLAGS_OFF: st_next.bresp = `CSFC_AXI_OKAY;
        default: st_next.bresp = `CSFC_AXI_SLVERR;
      endcase
    end
    if (st_reg.bvalid && s_axi_bready) begin
      st_next.bvalid = 1'b0;
    end

    // ==========================================================
    // axi4-lite read channel
    if (s_axi_arvalid && !st_reg.rvalid) begin
      st_next.rvalid = 1'b1;
      st_next.rresp = `CSFC_AXI_OKAY;
      unique case (s_axi_araddr)
        `CSFC_CTRL_OFF: st_next.rdata = st_reg.ctrl;
        `CSFC_STATUS_OFF: st_next.rdata = {15'h0, st_reg.fault_below, st_reg.cell_short,
                                           st_reg.in_short, 7'h0, st_reg.state};
        `CSFC_FLAGS_OFF: st_next.rdata = {20'h0, en_sync, fl};
        `CSFC_PRE_LIMIT_OFF: st_next.rdata = st_reg.pre_limit;
        `CSFC_CHG_LIMIT_OFF: st_next.rdata = st_reg.chg_limit;
        default: begin
          st_next.rdata = 32'h0;
          st_next.rresp = `CSFC_AXI_SLVERR;
        end
      endcase
    end else if (st_reg.rvalid && s_axi_rready) begin
      st_next.rvalid = 1'b0;
    end
    // readies kept in flops so every port leaves a register
    st_next.aw_rdy = !st_next.wa_have;
    st_next.w_rdy = !st_next.wd_have;
    st_next.ar_rdy = !st_next.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= '0;
      st_reg.state <= csfc_pkg::ST_SLEEP;
      st_reg.ctrl <= `CSFC_CTRL_RESET;
      st_reg.pre_limit <= `CSFC_PRE_LIMIT_RESET;
      st_reg.chg_limit <= `CSFC_CHG_LIMIT_RESET;
      st_reg.drv.cell_switch_on <= 1'b1;
      st_reg.aw_rdy <= 1'b1;
      st_reg.w_rdy <= 1'b1;
      st_reg.ar_rdy <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign drive = st_reg.drv;
  assign s_axi_awready = st_reg.aw_rdy;
  assign s_axi_wready = st_reg.w_rdy;
  assign s_axi_bvalid = st_reg.bvalid;
  assign s_axi_bresp = st_reg.bresp;
  assign s_axi_arready = st_reg.ar_rdy;
  assign s_axi_rvalid = st_reg.rvalid;
  assign s_axi_rdata = st_reg.rdata;
  assign s_axi_rresp = st_reg.rresp;

endmodule : csfc_charge_ctrl

//--- hw/csfc_consts.svh
// constants of the charge state and fault controller
// assumes: 20 mhz aclk, axi4-lite register access, analog flags from comparators
// Behaviour
// - terminate charge on termination flag in regulation
// - restart charge when cell below recharge threshold
// - no input supply puts charger to sleep
// - cell switch stays closed in sleep
// - low enable with input gives standby
// - status outputs encode charge state
// - power good low when input present
// - floating path pin stops charging
// - above-threshold fault waits for drop, restarts
// - reset or enable toggle clears fault
// - below-threshold fault enables probe current
// - rising above threshold stops probe, waits
// - output under one volt trips input short
// - output below cell trips cell short
// - path pin low suspends cell short protection
// - timer pin at reference disables timers, termination
// - out-of-window temperature suspends, timers held
// - charge timeout switches off, signals fault
// - low cell gets precharge current
`ifndef CSFC_CONSTS_SVH
`define CSFC_CONSTS_SVH

// ==========================================================
// register offsets and axi4-lite response codes
`define CSFC_CTRL_OFF 8'h00
`define CSFC_STATUS_OFF 8'h04
`define CSFC_FLAGS_OFF 8'h08
`define CSFC_PRE_LIMIT_OFF 8'h0c
`define CSFC_CHG_LIMIT_OFF 8'h10
`define CSFC_AXI_OKAY 2'h0
`define CSFC_AXI_SLVERR 2'h2

// ==========================================================
// control fields and reset values
`define CSFC_CTRL_EN_BIT 0
`define CSFC_CTRL_RESET 32'h0000_0001

// ==========================================================
// timing: timer tick every 1 ms, safety limits counted in ticks
`define CSFC_CLK_HZ 20000000
`define CSFC_TICK_US 1000
`define CSFC_TICK_CYCLES ((`CSFC_CLK_HZ / 1000000) * `CSFC_TICK_US)
`define CSFC_PRE_LIMIT_RESET 32'h0000_0708
`define CSFC_CHG_LIMIT_RESET 32'h0000_3840

`endif

//--- hw/csfc_pkg.sv
// types of the charge state and fault controller
// assumes: included constants header for numbers
package csfc_pkg;

  typedef enum logic [6:0] {
    ST_SLEEP = 7'h01,
    ST_STANDBY = 7'h02,
    ST_PRE = 7'h04,
    ST_FAST = 7'h08,
    ST_DONE = 7'h10,
    ST_SUSPEND = 7'h20,
    ST_FAULT = 7'h40
  } csfc_state_type;

  // comparator flags, all active high
  typedef struct packed {
    logic input_present;
    logic term_detect;
    logic in_regulation;
    logic below_recharge;
    logic below_precharge;
    logic out_below_1v;
    logic out_below_cell;
    logic temp_ok;
    logic path_floating;
    logic path_below_1v;
    logic timer_at_ref;
  } csfc_flags_type;

  typedef struct packed {
    logic input_switch_on;
    logic cell_switch_on;
    logic charge_switch_on;
    logic precharge_sel;
    logic fault_probe_current;
    logic input_pullup_on;
    logic cell_source_on;
    logic status_a_oe;
    logic status_b_oe;
    logic power_good_oe;
  } csfc_drive_type;

endpackage : csfc_pkg

//--- hw/csfc_sync3.sv
// three-stage synchroniser for a bundle of pin flags
// assumes: single aclk domain, inputs asynchronous
module csfc_sync3 #(
  parameter int WIDTH = 11
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // data
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] q;
  } csfc_sync_state_type;

  csfc_sync_state_type st_reg;
  csfc_sync_state_type st_next;

  always_comb begin
    st_next = st_reg;
    st_next.s1 = din;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    // a change counts only once stages two and three agree
    for (int i = 0; i < WIDTH; i++) begin
      if (st_reg.s2[i] == st_reg.s3[i]) begin
        st_next.q[i] = st_reg.s3[i];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign dout = st_reg.q;

endmodule : csfc_sync3

//--- sim/csfc_charge_ctrl_sva.sv
// pin relations of the charge controller
// assumes: bound to csfc_charge_ctrl, one aclk domain
module csfc_charge_ctrl_sva (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // pins
  input wire csfc_pkg::csfc_flags_type flags_in,
  input wire logic chip_enable,
  input wire csfc_pkg::csfc_drive_type drive
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ==========================================
  // flag levels
  // eight samples cover sync, filter and drive latency
  a_sleep_cell: assert property (
    (!flags_in.input_present && !flags_in.out_below_cell)[*8]
    |-> drive.cell_switch_on && !drive.power_good_oe && !drive.status_a_oe)
    else $error("sleep drive wrong");
  a_pg_present: assert property (
    flags_in.input_present[*8] |-> drive.power_good_oe)
    else $error("power good not on");
  a_standby_off: assert property (
    (flags_in.input_present && !chip_enable)[*8]
    |-> !drive.input_switch_on && !drive.charge_switch_on)
    else $error("standby drive wrong");
  a_float_stop: assert property (
    flags_in.path_floating[*8] |-> !drive.charge_switch_on)
    else $error("charging with floating pin");
  a_temp_hold: assert property (
    (!flags_in.temp_ok)[*8] |-> !drive.charge_switch_on && !drive.status_a_oe)
    else $error("charging out of window");
  a_in_short: assert property (
    (flags_in.input_present && flags_in.out_below_1v)[*8]
    |-> !drive.input_switch_on && drive.input_pullup_on)
    else $error("input short not handled");
  a_cell_short: assert property (
    (flags_in.out_below_cell && !flags_in.path_below_1v)[*8]
    |-> !drive.cell_switch_on && drive.cell_source_on)
    else $error("cell short not handled");
  a_short_defeat: assert property (
    flags_in.path_below_1v[*8] |-> !drive.cell_source_on)
    else $error("cell short not suspended");
  // ==========================================
  // state coding
  a_status_code: assert property (
    drive.status_a_oe |-> drive.status_b_oe == drive.precharge_sel)
    else $error("status code mismatch");
  a_probe_fault: assert property (
    drive.fault_probe_current
    |-> !drive.status_a_oe && !drive.status_b_oe && !drive.charge_switch_on)
    else $error("probe outside fault");
endmodule : csfc_charge_ctrl_sva

bind csfc_charge_ctrl csfc_charge_ctrl_sva u_sva (.aclk(aclk), .aresetn(aresetn),
  .flags_in(flags_in), .chip_enable(chip_enable), .drive(drive));

//--- sim/csfc_host_model.sv
// host side of the indicator pins: pull-ups on open drains
// assumes: an enable high pulls its pin low
module csfc_host_model (
  // pad enables
  input wire logic status_a_oe,
  input wire logic status_b_oe,
  input wire logic power_good_oe,
  // levels seen by the host
  output logic status_a_n,
  output logic status_b_n,
  output logic power_good_n
);
  // released pins rise through the pull-ups
  assign status_a_n = status_a_oe ? 1'b0 : 1'b1;
  assign status_b_n = status_b_oe ? 1'b0 : 1'b1;
  assign power_good_n = power_good_oe ? 1'b0 : 1'b1;
endmodule : csfc_host_model

//--- sim/tb_top.sv
// self-checking bench of the charge controller
// assumes: host model on indicator pins, axi4-lite master here
`include "csfc_consts.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic chip_enable = 1'b0;
  csfc_pkg::csfc_flags_type fl = '0;
  csfc_pkg::csfc_drive_type drive;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, d, rv;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, sa_n, sb_n, pg_n;
  logic [1:0] bresp, rresp, r;
  int error_cnt = 0;
  int checks = 0;
  int tn = 0;
  always #25 aclk = ~aclk;
  csfc_charge_ctrl dut (.aclk(aclk), .aresetn(aresetn), .flags_in(fl),
    .chip_enable(chip_enable), .drive(drive), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));
  csfc_host_model host (.status_a_oe(drive.status_a_oe), .status_b_oe(drive.status_b_oe),
    .power_good_oe(drive.power_good_oe), .status_a_n(sa_n), .status_b_n(sb_n),
    .power_good_n(pg_n));
  // ==========================================
  // bus master
  task automatic axw(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    rs = bresp;
    bready <= 1'b0;
  endtask : axw
  task automatic axr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    v = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask : axr
  // ==========================================
  // model and compares
  // {input sw, cell sw, charge sw, status a on, status b on, power good on}
  function automatic logic [5:0] pat(input logic [6:0] st);
    case (st)
      7'h01: return 6'b010000;
      7'h02: return 6'b010001;
      7'h04: return 6'b111111;
      7'h08: return 6'b111101;
      7'h10: return 6'b110011;
      default: return 6'b110001;
    endcase
  endfunction : pat
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_reg
  task automatic chk_pins(input logic [5:0] got, input logic [5:0] exp);
    chk_reg({26'h0, got}, {26'h0, exp});
  endtask : chk_pins
  task automatic settle;
    repeat (12) @(posedge aclk);
  endtask : settle
  task automatic chk(input logic [6:0] st);
    settle();
    chk_pins({drive.input_switch_on, drive.cell_switch_on, drive.charge_switch_on,
      ~sa_n, ~sb_n, ~pg_n}, pat(st));
    chk_pins({5'h0, drive.precharge_sel}, {5'h0, st == 7'h04});
    axr(8'h04, rv, r);
    chk_reg({25'h0, rv[6:0]}, {25'h0, st});
  endtask : chk
  task automatic tdone;
    $display("test %0d done", tn);
    tn++;
  endtask : tdone
  // timer fault needs up to one limit tick
  task automatic wait_off;
    int n;
    n = 0;
    while (drive.charge_switch_on !== 1'b0 && n < 45000) begin
      @(posedge aclk);
      n++;
    end
  endtask : wait_off
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (100000) @(posedge aclk);
    error_cnt++;
    report_and_stop();
  end
  // ==========================================
  // tests
  initial begin
    void'($urandom(32'h8bad0416));
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    chk(7'h01);
    axr(8'h00, rv, r);
    chk_reg(rv, `CSFC_CTRL_RESET);
    axr(8'h0c, rv, r);
    chk_reg(rv, `CSFC_PRE_LIMIT_RESET);
    axr(8'h10, rv, r);
    chk_reg(rv, `CSFC_CHG_LIMIT_RESET);
    axr(8'h20, rv, r);
    chk_reg({rv[29:0], r}, {30'h0, `CSFC_AXI_SLVERR});
    d = 32'h1000 + ($urandom & 32'hffff);
    axw(8'h20, d, r);
    chk_reg({30'h0, r}, {30'h0, `CSFC_AXI_SLVERR});
    axw(8'h10, d, r);
    axr(8'h10, rv, r);
    chk_reg(rv, d);
    tdone();
    fl.input_present <= 1'b1;
    fl.temp_ok <= 1'b1;
    fl.below_precharge <= 1'b1;
    chk(7'h02);
    chip_enable <= 1'b1;
    chk(7'h04);
    fl.below_precharge <= 1'b0;
    chk(7'h08);
    fl.timer_at_ref <= 1'b1;
    fl.term_detect <= 1'b1;
    fl.in_regulation <= 1'b1;
    chk(7'h08);
    fl.timer_at_ref <= 1'b0;
    chk(7'h10);
    axw(8'h08, 32'hffff_ffff, r);
    axr(8'h08, rv, r);
    chk_reg(rv, {20'h0, chip_enable, fl});
    fl.term_detect <= 1'b0;
    fl.below_recharge <= 1'b1;
    chk(7'h08);
    fl.below_recharge <= 1'b0;
    fl.in_regulation <= 1'b0;
    fl.temp_ok <= 1'b0;
    chk(7'h20);
    fl.temp_ok <= 1'b1;
    chk(7'h08);
    fl.path_floating <= 1'b1;
    settle();
    chk_pins({5'h0, drive.charge_switch_on}, 6'h0);
    fl.path_floating <= 1'b0;
    chk(7'h08);
    tdone();
    fl.out_below_1v <= 1'b1;
    settle();
    chk_pins({4'h0, drive.input_switch_on, drive.input_pullup_on}, 6'h1);
    fl.out_below_1v <= 1'b0;
    fl.out_below_cell <= 1'b1;
    settle();
    chk_pins({4'h0, drive.cell_switch_on, drive.cell_source_on}, 6'h1);
    fl.path_below_1v <= 1'b1;
    settle();
    chk_pins({4'h0, drive.cell_switch_on, drive.cell_source_on}, 6'h2);
    fl.path_below_1v <= 1'b0;
    fl.out_below_cell <= 1'b0;
    chk(7'h08);
    axw(8'h00, 32'h0, r);
    chk(7'h02);
    axw(8'h00, 32'h1, r);
    chk(7'h08);
    tdone();
    axw(8'h0c, 32'h1, r);
    fl.below_precharge <= 1'b1;
    fl.below_recharge <= 1'b1;
    chk(7'h04);
    wait_off();
    chk(7'h40);
    chk_pins({5'h0, drive.fault_probe_current}, 6'h1);
    fl.below_recharge <= 1'b0;
    chk(7'h40);
    chk_pins({5'h0, drive.fault_probe_current}, 6'h0);
    fl.below_recharge <= 1'b1;
    chk(7'h04);
    wait_off();
    chk(7'h40);
    chip_enable <= 1'b0;
    settle();
    chip_enable <= 1'b1;
    chk(7'h04);
    tdone();
    report_and_stop();
  end
endmodule : tb_top
